// ===== logic/cts_pkg.sv
// Constants and types for the cache target select and stash front end
// How it works
// - Target 0 selects primary data cache
// - Target 1 selects platform I/O cache
// - Target 2 selects own secondary cache
// - Values 0 and 2 never stash identifiers
// - Only 3, 5, 7 valid stash identifiers
// - Values 4, 6, 8-31 reserved
// - Zero identifier disables stashing for that cache
// - Identifiers come from control register fields
// - Translation always on, no real mode
// - Missing entry raises matching miss interrupt
// - Faults precise, faulting state preserved
// - Caches tagged with real addresses
// - Write-through primary keeps dirty data secondary
// - Secondary supports core and primary coherency
// - Fetches ignore guarded attribute
// - Non-snooping primary data ignores coherence bit
// - Primary instruction cache does not snoop
// - Real address width 32 to 64
// - Pages set translation granularity, sizes varied; here one fixed 4 KB page size (PAGE_SH = 12)
package cts_pkg;
    localparam int CT_W       = 5;
    localparam int ID_W       = 5;
    localparam int EA_W       = 32;
    localparam int RA_W       = 36;
    localparam int PAGE_SH    = 12;
    localparam int VPN_W      = EA_W - PAGE_SH;
    localparam int RPN_W      = RA_W - PAGE_SH;
    localparam int TLB_N      = 8;
    localparam int TLB_IW     = 3;
    localparam logic [CT_W-1:0] CT_PRIMARY   = 5'h00;
    localparam logic [CT_W-1:0] CT_PLATFORM  = 5'h01;
    localparam logic [CT_W-1:0] CT_SECONDARY = 5'h02;
    localparam logic [CT_W-1:0] ID_EXT_A     = 5'h03;
    localparam logic [CT_W-1:0] ID_EXT_B     = 5'h05;
    localparam logic [CT_W-1:0] ID_EXT_C     = 5'h07;
    localparam logic [ID_W-1:0] ID_NONE      = 5'h00;
    // Attribute bit positions
    localparam int ATTR_W = 5;
    localparam int ATTR_G = 1;
    localparam int ATTR_M = 2;
    localparam int ATTR_I = 3;
    localparam int ATTR_W_T = 4;

    typedef enum logic [3:0] {
        CTS_TGT_NONE      = 4'h1,
        CTS_TGT_PRIMARY   = 4'h2,
        CTS_TGT_PLATFORM  = 4'h4,
        CTS_TGT_SECONDARY = 4'h8
    } cts_tgt_t;

    typedef enum logic [2:0] {
        CTS_ST_IDLE  = 3'h1,
        CTS_ST_DONE  = 3'h2,
        CTS_ST_FAULT = 3'h4
    } cts_st_t;
endpackage

// ===== logic/cts_tlb_mem.sv
// Small translation entry store with registered read data
`timescale 1ns/100ps
module cts_tlb_mem
    import cts_pkg::*;
(
    input  wire logic                 clk,          // Clock
    input  wire logic                 rst_n,        // Sync reset
    input  wire logic                 ce,           // Clock enable
    input  wire logic                 wr_en,        // Write entry
    input  wire logic [TLB_IW-1:0]    wr_idx,       // Write index
    input  wire logic [VPN_W-1:0]     wr_vpn,       // Virtual page
    input  wire logic [RPN_W-1:0]     wr_rpn,       // Real page
    input  wire logic [ATTR_W-1:0]    wr_attr,      // Attributes
    input  wire logic                 wr_valid,     // Entry valid
    input  wire logic [VPN_W-1:0]     lk_vpn,       // Lookup page
    output logic                      hit_q,        // Lookup hit
    output logic [RPN_W-1:0]          rpn_q,        // Lookup real page
    output logic [ATTR_W-1:0]         attr_q        // Lookup attributes
);
    logic [VPN_W-1:0]  vpn_q  [TLB_N];
    logic [RPN_W-1:0]  rpnm_q [TLB_N];
    logic [ATTR_W-1:0] atm_q  [TLB_N];
    logic [TLB_N-1:0]  val_q;
    logic              hit_d;
    logic [RPN_W-1:0]  rpn_d;
    logic [ATTR_W-1:0] attr_d;

    always_comb begin
        hit_d  = 1'b0;
        rpn_d  = '0;
        attr_d = '0;
        for (int i = 0; i < TLB_N; i++) begin
            if (val_q[i] && vpn_q[i] == lk_vpn) begin
                hit_d  = 1'b1;
                rpn_d  = rpnm_q[i];
                attr_d = atm_q[i];
            end
        end
    end

    genvar g;
    for (g = 0; g < TLB_N; g++) begin : g_ent
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                val_q[g]  <= 1'b0;
                vpn_q[g]  <= '0;
                rpnm_q[g] <= '0;
                atm_q[g]  <= '0;
            end else if (ce && wr_en && wr_idx == TLB_IW'(g)) begin
                val_q[g]  <= wr_valid;
                vpn_q[g]  <= wr_vpn;
                rpnm_q[g] <= wr_rpn;
                atm_q[g]  <= wr_attr;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hit_q  <= 1'b0;
            rpn_q  <= '0;
            attr_q <= '0;
        end else if (ce) begin
            hit_q  <= hit_d;
            rpn_q  <= rpn_d;
            attr_q <= attr_d;
        end
    end
endmodule

// ===== logic/cts_front.sv
// Cache target decode, stash identifier match and always-on translation
`timescale 1ns/100ps
module cts_front
    import cts_pkg::*;
(
    input  wire logic                 clk,                 // Clock, 10 MHz
    input  wire logic                 rst_n,               // Sync reset, low
    input  wire logic                 ce,                  // Clock enable
    // Control register fields
    input  wire logic [ID_W-1:0]      primary_stash_ident,   // Primary stash id
    input  wire logic [ID_W-1:0]      secondary_stash_ident, // Secondary stash id
    input  wire logic                 l1d_write_through,   // Primary write-through
    input  wire logic                 l1d_snoop_en,        // Primary data snoops
    // Pipeline cache op
    input  wire logic                 cop_valid,           // Cache op request
    input  wire logic [CT_W-1:0]      cache_target_field,  // Target field
    output logic                      cop_done_q,          // Decode done pulse
    output cts_pkg::cts_tgt_t         cop_tgt_q,           // Decoded target
    // External stash request (from pins)
    input  wire logic                 stash_req,           // Stash request
    input  wire logic [ID_W-1:0]      stash_id,            // Requested id
    input  wire logic [RA_W-1:0]      stash_addr,          // Real address
    output logic                      stash_l1_q,          // Prefetch to primary
    output logic                      stash_l2_q,          // Prefetch to secondary
    output logic                      stash_drop_q,        // Request ignored
    output logic [RA_W-1:0]           stash_addr_q,        // Prefetch address
    // Translation entry write
    input  wire logic                 tlb_wr,              // Write entry
    input  wire logic [TLB_IW-1:0]    tlb_idx,             // Entry index
    input  wire logic [VPN_W-1:0]     tlb_vpn,             // Virtual page
    input  wire logic [RPN_W-1:0]     tlb_rpn,             // Real page
    input  wire logic [ATTR_W-1:0]    memory_attr_bits,    // Page attributes
    input  wire logic                 tlb_valid,           // Entry valid
    // Access translation
    input  wire logic                 acc_valid,           // Access request
    input  wire logic                 acc_fetch,           // Fetch, else data
    input  wire logic                 acc_store,           // Data store
    input  wire logic [EA_W-1:0]      effective_addr,      // Access address
    output logic                      acc_ready,           // Can take request
    output logic                      acc_done_q,          // Translated pulse
    output logic [RA_W-1:0]           real_addr_q,         // Real address tag
    output logic                      acc_cacheable_q,     // Cache may allocate
    output logic                      acc_coherent_q,      // Snoop coherent
    output logic                      acc_l2_dirty_q,      // Dirty kept secondary
    output logic                      itlb_miss_q,         // Fetch miss pulse
    output logic                      dtlb_miss_q,         // Data miss pulse
    output logic                      prot_fault_q,        // Protection fault
    output logic [EA_W-1:0]           fault_ea_q,          // Faulting address
    output logic                      fault_store_q,       // Fault was store
    input  wire logic                 fault_ack            // Handler restart
);
    import cts_pkg::*;

    function automatic logic id_usable(input logic [ID_W-1:0] id);
        return id == ID_EXT_A || id == ID_EXT_B || id == ID_EXT_C;
    endfunction

    // Pin synchronisers for the stash request
    logic            sreq_s1_q, sreq_s2_q;
    logic [ID_W-1:0] sid_s1_q, sid_s2_q;
    logic [RA_W-1:0] sad_s1_q, sad_s2_q;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sreq_s1_q <= 1'b0;
            sreq_s2_q <= 1'b0;
            sid_s1_q  <= '0;
            sid_s2_q  <= '0;
            sad_s1_q  <= '0;
            sad_s2_q  <= '0;
        end else if (ce) begin
            sreq_s1_q <= stash_req;
            sreq_s2_q <= sreq_s1_q;
            sid_s1_q  <= stash_id;
            sid_s2_q  <= sid_s1_q;
            sad_s1_q  <= stash_addr;
            sad_s2_q  <= sad_s1_q;
        end
    end

    // Cache target decode
    logic     cop_done_d;
    cts_tgt_t cop_tgt_d;
    always_comb begin
        cop_done_d = cop_valid;
        cop_tgt_d  = cop_tgt_q;
        if (cop_valid) begin
            case (cache_target_field)
                CT_PRIMARY:   cop_tgt_d = CTS_TGT_PRIMARY;
                CT_PLATFORM:  cop_tgt_d = CTS_TGT_PLATFORM;
                CT_SECONDARY: cop_tgt_d = CTS_TGT_SECONDARY;
                default:      cop_tgt_d = CTS_TGT_NONE;
            endcase
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cop_done_q <= 1'b0;
            cop_tgt_q  <= CTS_TGT_NONE;
        end else if (ce) begin
            cop_done_q <= cop_done_d;
            cop_tgt_q  <= cop_tgt_d;
        end
    end

    // Stash match: identifiers from control fields, zero disables
    logic            sreq_d1_q;
    logic            stash_l1_d, stash_l2_d, stash_drop_d;
    logic [RA_W-1:0] stash_addr_d;
    logic            sreq_rise;
    assign sreq_rise = sreq_s2_q && !sreq_d1_q;
    always_comb begin
        stash_l1_d   = 1'b0;
        stash_l2_d   = 1'b0;
        stash_drop_d = 1'b0;
        stash_addr_d = stash_addr_q;
        if (sreq_rise) begin
            if (id_usable(sid_s2_q) && sid_s2_q != ID_NONE) begin
                stash_l1_d = sid_s2_q == primary_stash_ident;
                stash_l2_d = sid_s2_q == secondary_stash_ident;
            end
            stash_drop_d = !(stash_l1_d || stash_l2_d);
            if (!stash_drop_d) begin
                stash_addr_d = sad_s2_q;
            end
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sreq_d1_q    <= 1'b0;
            stash_l1_q   <= 1'b0;
            stash_l2_q   <= 1'b0;
            stash_drop_q <= 1'b0;
            stash_addr_q <= '0;
        end else if (ce) begin
            sreq_d1_q    <= sreq_s2_q;
            stash_l1_q   <= stash_l1_d;
            stash_l2_q   <= stash_l2_d;
            stash_drop_q <= stash_drop_d;
            stash_addr_q <= stash_addr_d;
        end
    end

    // Translation: every access goes through the entry store
    logic              hit;
    logic [RPN_W-1:0]  rpn;
    logic [ATTR_W-1:0] attr;
    cts_tlb_mem u_tlb (
        .clk      (clk),
        .rst_n    (rst_n),
        .ce       (ce),
        .wr_en    (tlb_wr),
        .wr_idx   (tlb_idx),
        .wr_vpn   (tlb_vpn),
        .wr_rpn   (tlb_rpn),
        .wr_attr  (memory_attr_bits),
        .wr_valid (tlb_valid),
        .lk_vpn   (effective_addr[EA_W-1:PAGE_SH]),
        .hit_q    (hit),
        .rpn_q    (rpn),
        .attr_q   (attr)
    );

    cts_st_t         st_q, st_d;
    logic            pend_q, pend_d;
    logic            fetch_q, fetch_d, store_q, store_d;
    logic [EA_W-1:0] ea_q, ea_d;
    logic            done_d, imiss_d, dmiss_d, pf_d, cach_d, coh_d, dirty_d;
    logic [RA_W-1:0] ra_d;
    logic [EA_W-1:0] fea_d;
    logic            fst_d;
    logic            guard_fault;

    assign acc_ready   = st_q == CTS_ST_IDLE && !pend_q;
    // Fetch ignores guarded; store to guarded page is the protection fault here
    assign guard_fault = !fetch_q && store_q && attr[ATTR_G];

    always_comb begin
        st_d    = st_q;
        pend_d  = pend_q;
        fetch_d = fetch_q;
        store_d = store_q;
        ea_d    = ea_q;
        done_d  = 1'b0;
        imiss_d = 1'b0;
        dmiss_d = 1'b0;
        pf_d    = 1'b0;
        ra_d    = real_addr_q;
        cach_d  = acc_cacheable_q;
        coh_d   = acc_coherent_q;
        dirty_d = acc_l2_dirty_q;
        fea_d   = fault_ea_q;
        fst_d   = fault_store_q;
        case (st_q)
            CTS_ST_IDLE: begin
                if (pend_q) begin
                    pend_d = 1'b0;
                    if (!hit) begin
                        imiss_d = fetch_q;
                        dmiss_d = !fetch_q;
                        fea_d   = ea_q;
                        fst_d   = store_q;
                        st_d    = CTS_ST_FAULT;
                    end else if (guard_fault) begin
                        pf_d  = 1'b1;
                        fea_d = ea_q;
                        fst_d = store_q;
                        st_d  = CTS_ST_FAULT;
                    end else begin
                        done_d  = 1'b1;
                        ra_d    = {rpn, ea_q[PAGE_SH-1:0]};
                        cach_d  = !attr[ATTR_I];
                        coh_d   = attr[ATTR_M] && (fetch_q ? 1'b0 : l1d_snoop_en);
                        dirty_d = store_q && l1d_write_through;
                    end
                end else if (acc_valid) begin
                    pend_d  = 1'b1;
                    fetch_d = acc_fetch;
                    store_d = acc_store && !acc_fetch;
                    ea_d    = effective_addr;
                end
            end
            CTS_ST_FAULT: begin
                if (fault_ack) begin
                    st_d = CTS_ST_IDLE;
                end
            end
            default: st_d = CTS_ST_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_q            <= CTS_ST_IDLE;
            pend_q          <= 1'b0;
            fetch_q         <= 1'b0;
            store_q         <= 1'b0;
            ea_q            <= '0;
            acc_done_q      <= 1'b0;
            itlb_miss_q     <= 1'b0;
            dtlb_miss_q     <= 1'b0;
            prot_fault_q    <= 1'b0;
            real_addr_q     <= '0;
            acc_cacheable_q <= 1'b0;
            acc_coherent_q  <= 1'b0;
            acc_l2_dirty_q  <= 1'b0;
            fault_ea_q      <= '0;
            fault_store_q   <= 1'b0;
        end else if (ce) begin
            st_q            <= st_d;
            pend_q          <= pend_d;
            fetch_q         <= fetch_d;
            store_q         <= store_d;
            ea_q            <= ea_d;
            acc_done_q      <= done_d;
            itlb_miss_q     <= imiss_d;
            dtlb_miss_q     <= dmiss_d;
            prot_fault_q    <= pf_d;
            real_addr_q     <= ra_d;
            acc_cacheable_q <= cach_d;
            acc_coherent_q  <= coh_d;
            acc_l2_dirty_q  <= dirty_d;
            fault_ea_q      <= fea_d;
            fault_store_q   <= fst_d;
        end
    end

    a_target_primary: assert property (@(posedge clk) disable iff (!rst_n)
        ce && cop_valid && cache_target_field == CT_PRIMARY
        |=> cop_done_q && cop_tgt_q == CTS_TGT_PRIMARY)
        else $error("target 0 not primary");
    a_target_platform: assert property (@(posedge clk) disable iff (!rst_n)
        ce && cop_valid && cache_target_field == CT_PLATFORM
        |=> cop_tgt_q == CTS_TGT_PLATFORM)
        else $error("target 1 not platform");
    a_target_second: assert property (@(posedge clk) disable iff (!rst_n)
        ce && cop_valid && cache_target_field == CT_SECONDARY
        |=> cop_tgt_q == CTS_TGT_SECONDARY)
        else $error("target 2 not secondary");
    a_stash_legal_id: assert property (@(posedge clk) disable iff (!rst_n)
        ce && (stash_l1_d || stash_l2_d) |-> id_usable(sid_s2_q))
        else $error("stash accepted with illegal id");
    a_stash_zero_off: assert property (@(posedge clk) disable iff (!rst_n)
        ce && (stash_l1_d || stash_l2_d)
        |-> (!stash_l1_d || primary_stash_ident != ID_NONE)
        && (!stash_l2_d || secondary_stash_ident != ID_NONE))
        else $error("stash with zero identifier");
    a_stash_drop_one: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(stash_drop_q) |-> !stash_l1_q && !stash_l2_q
        && $stable(stash_addr_q))
        else $error("dropped stash changed state");
    a_miss_kind: assert property (@(posedge clk) disable iff (!rst_n)
        ce && pend_q && st_q == CTS_ST_IDLE && !hit
        |=> (itlb_miss_q ^ dtlb_miss_q) && itlb_miss_q == $past(fetch_q))
        else $error("wrong miss kind");
    a_fault_hold: assert property (@(posedge clk) disable iff (!rst_n)
        st_q == CTS_ST_FAULT && !fault_ack |=> st_q == CTS_ST_FAULT
        && $stable(fault_ea_q))
        else $error("fault state lost");
endmodule

// ===== test/cts_stash_dev.sv
// Model of an outside device that issues cache stash hints
`timescale 1ns/100ps
module cts_stash_dev (
    input  wire logic                       clk,        // Clock
    output logic                            stash_req,  // Stash request level
    output logic [cts_pkg::ID_W-1:0]        stash_id,   // Named cache
    output logic [cts_pkg::RA_W-1:0]        stash_addr  // Address to prefetch
);
    import cts_pkg::*;

    initial begin
        stash_req  = 1'b0;
        stash_id   = 5'h1A;
        stash_addr = 36'h5A5A5A5A5;
    end

    // One hint; the id is whatever the bench commands, reserved ones too
    task automatic send(input logic [ID_W-1:0] id, input logic [RA_W-1:0] addr);
        begin
            @(posedge clk);
            #2;
            stash_id   = id;
            stash_addr = addr;
            stash_req  = 1'b1;
            repeat (4) @(posedge clk);
            #2;
            stash_req  = 1'b0;
            // Released lines float, so show the inverse rather than the old value
            stash_id   = ~id;
            stash_addr = ~addr;
            repeat (3) @(posedge clk);
        end
    endtask
endmodule

// ===== test/tb_top.sv
// Self-checking bench for the cache target select and stash front end
`timescale 1ns/100ps
module tb_top;
    import cts_pkg::*;
    logic              clk, rst_n, ce, l1d_write_through, l1d_snoop_en, fault_ack;
    logic              cop_valid, cop_done_q, stash_req, stash_l1_q, stash_l2_q, stash_drop_q;
    logic              tlb_wr, tlb_valid, acc_valid, acc_fetch, acc_store, acc_ready;
    logic              acc_done_q, acc_cacheable_q, acc_coherent_q, acc_l2_dirty_q;
    logic              itlb_miss_q, dtlb_miss_q, prot_fault_q, fault_store_q;
    logic [ID_W-1:0]   primary_stash_ident, secondary_stash_ident, stash_id;
    logic [CT_W-1:0]   cache_target_field;
    logic [RA_W-1:0]   stash_addr, stash_addr_q, real_addr_q, last_addr;
    logic [TLB_IW-1:0] tlb_idx;
    logic [VPN_W-1:0]  tlb_vpn;
    logic [RPN_W-1:0]  tlb_rpn;
    logic [ATTR_W-1:0] memory_attr_bits;
    logic [EA_W-1:0]   effective_addr, fault_ea_q;
    cts_tgt_t          cop_tgt_q;
    int                n_mismatch, n_tests;

    cts_front u_cts_front (.clk, .rst_n, .ce, .primary_stash_ident, .secondary_stash_ident,
        .l1d_write_through, .l1d_snoop_en, .cop_valid, .cache_target_field, .cop_done_q,
        .cop_tgt_q, .stash_req, .stash_id, .stash_addr, .stash_l1_q, .stash_l2_q,
        .stash_drop_q, .stash_addr_q, .tlb_wr, .tlb_idx, .tlb_vpn, .tlb_rpn,
        .memory_attr_bits, .tlb_valid, .acc_valid, .acc_fetch, .acc_store, .effective_addr,
        .acc_ready, .acc_done_q, .real_addr_q, .acc_cacheable_q, .acc_coherent_q,
        .acc_l2_dirty_q, .itlb_miss_q, .dtlb_miss_q, .prot_fault_q, .fault_ea_q,
        .fault_store_q, .fault_ack);
    cts_stash_dev u_cts_stash_dev (.clk, .stash_req, .stash_id, .stash_addr);

    initial clk = 1'b0;
    always #50 clk = ~clk;

    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic timeout(input string name);
        n_mismatch++;
        $display("mismatch %s expected answer seen none", name);
        summarize();
    endtask

    function automatic cts_tgt_t exp_tgt(input int v);
        case (v)
            0:       return CTS_TGT_PRIMARY;
            1:       return CTS_TGT_PLATFORM;
            2:       return CTS_TGT_SECONDARY;
            default: return CTS_TGT_NONE;
        endcase
    endfunction

    // Only 3, 5 and 7 may name a cache, and only one whose ident is set to it
    function automatic logic hit(input logic [ID_W-1:0] id, input logic [ID_W-1:0] ident);
        return (id == 5'h03 || id == 5'h05 || id == 5'h07) && id == ident;
    endfunction

    task automatic stash(input logic [ID_W-1:0] id);
        logic [RA_W-1:0] a;
        logic            e1, e2;
        int              n;
        a  = {31'h0ACE135, id};
        e1 = hit(id, primary_stash_ident);
        e2 = hit(id, secondary_stash_ident);
        fork
            u_cts_stash_dev.send(id, a);
            begin
                @(posedge clk);
                n = 0;
                while (n < 8 && !(stash_l1_q || stash_l2_q || stash_drop_q)) begin
                    @(posedge clk);
                    #2;
                    n++;
                end
                if (n == 8) timeout("stash answer");
                check("stash latency", n, 3);
                check("stash_l1_q", stash_l1_q, e1);
                check("stash_l2_q", stash_l2_q, e2);
                check("stash_drop_q", stash_drop_q, !(e1 || e2));
                if (e1 || e2) last_addr = a;
                check("stash_addr_q", stash_addr_q, last_addr);
                @(posedge clk);
                #2;
                check("stash pulse", {stash_l1_q, stash_l2_q, stash_drop_q}, 3'h0);
            end
        join
    endtask

    task automatic tlb_put(input logic [TLB_IW-1:0] i, input logic [VPN_W-1:0] v,
                           input logic [RPN_W-1:0] r, input logic [ATTR_W-1:0] at,
                           input logic ok);
        @(posedge clk);
        #2;
        tlb_wr           = 1'b1;
        tlb_idx          = i;
        tlb_vpn          = v;
        tlb_rpn          = r;
        memory_attr_bits = at;
        tlb_valid        = ok;
        @(posedge clk);
        #2;
        tlb_wr = 1'b0;
    endtask

    // ans is {prot, dtlb miss, itlb miss, done}; at is {cacheable, coherent, dirty}
    task automatic access(input logic fe, input logic st, input logic [EA_W-1:0] ea,
                          input logic [3:0] ans, input logic [RA_W-1:0] ra,
                          input logic [2:0] at);
        int n;
        @(posedge clk);
        #2;
        n = 0;
        while (n < 8 && acc_ready !== 1'b1) begin
            @(posedge clk);
            #2;
            n++;
        end
        if (n == 8) timeout("acc_ready");
        acc_valid      = 1'b1;
        acc_fetch      = fe;
        acc_store      = st;
        effective_addr = ea;
        @(posedge clk);
        #2;
        acc_valid = 1'b0;
        n = 1;
        while (n < 8 && !(acc_done_q || itlb_miss_q || dtlb_miss_q || prot_fault_q)) begin
            @(posedge clk);
            #2;
            n++;
        end
        if (n == 8) timeout("access answer");
        // Lookup is registered on the taking edge, so the answer follows one edge later
        check("acc latency", n, 2);
        check("acc answer", {prot_fault_q, dtlb_miss_q, itlb_miss_q, acc_done_q}, ans);
        if (ans[0]) begin
            check("real_addr_q", real_addr_q, ra);
            check("acc attrs", {acc_cacheable_q, acc_coherent_q, acc_l2_dirty_q}, at);
        end else begin
            check("fault_ea_q", fault_ea_q, ea);
            check("fault_store_q", fault_store_q, st);
            check("acc_ready", acc_ready, 1'b0);
            fault_ack = 1'b1;
            @(posedge clk);
            #2;
            fault_ack = 1'b0;
        end
    endtask

    initial begin
        {rst_n, l1d_write_through, l1d_snoop_en, fault_ack, cop_valid, tlb_wr} = '0;
        {tlb_valid, acc_valid, acc_fetch, acc_store, cache_target_field} = '0;
        {tlb_idx, tlb_vpn, tlb_rpn, memory_attr_bits, effective_addr, last_addr} = '0;
        {n_mismatch, n_tests} = '0;
        ce                    = 1'b1;
        primary_stash_ident   = 5'h03;
        secondary_stash_ident = 5'h05;
        repeat (8) @(posedge clk);
        #2;
        rst_n = 1'b1;
        check("cop_tgt_q reset", cop_tgt_q, CTS_TGT_NONE);
        check("acc_ready reset", acc_ready, 1'b1);
        // Clock enable low must freeze the decode even with a request present
        ce                 = 1'b0;
        cop_valid          = 1'b1;
        cache_target_field = CT_SECONDARY;
        @(posedge clk);
        #2;
        check("cop frozen", {cop_done_q, cop_tgt_q}, {1'b0, CTS_TGT_NONE});
        ce        = 1'b1;
        cop_valid = 1'b0;
        // Every target value, back to back
        for (int i = 0; i <= 32; i++) begin
            @(posedge clk);
            #2;
            if (i > 0) begin
                check("cop_done_q", cop_done_q, 1'b1);
                check("cop_tgt_q", cop_tgt_q, exp_tgt(i - 1));
            end
            cop_valid          = (i < 32);
            cache_target_field = i[CT_W-1:0];
        end
        for (int i = 0; i < 32; i++) stash(i[ID_W-1:0]);
        // Zero ident shuts a cache off; a shared ident fires both
        #2;
        primary_stash_ident   = 5'h00;
        secondary_stash_ident = 5'h07;
        stash(5'h03);
        stash(5'h07);
        #2;
        primary_stash_ident = 5'h07;
        stash(5'h07);
        tlb_put(3'h0, 20'h00010, 24'hABC123, 5'h04, 1'b1);
        tlb_put(3'h1, 20'h00020, 24'h000456, 5'h0A, 1'b1);
        tlb_put(3'h2, 20'h00030, 24'h000789, 5'h00, 1'b0);
        tlb_put(3'h7, 20'hFFFFF, 24'hFFFFFF, 5'h00, 1'b1);
        l1d_snoop_en = 1'b1;
        access(1'b0, 1'b0, 32'h00010345, 4'h1, 36'hABC123345, 3'b110);
        l1d_write_through = 1'b1;
        access(1'b0, 1'b1, 32'h00010FFC, 4'h1, 36'hABC123FFC, 3'b111);
        l1d_snoop_en = 1'b0;
        access(1'b0, 1'b0, 32'h00010000, 4'h1, 36'hABC123000, 3'b100);
        access(1'b1, 1'b0, 32'h00020010, 4'h1, 36'h000456010, 3'b000);
        access(1'b0, 1'b0, 32'h00020004, 4'h1, 36'h000456004, 3'b000);
        access(1'b0, 1'b0, 32'hFFFFF001, 4'h1, 36'hFFFFFF001, 3'b100);
        access(1'b1, 1'b0, 32'h00040000, 4'h2, '0, '0);
        access(1'b0, 1'b0, 32'h00030004, 4'h4, '0, '0);
        access(1'b0, 1'b1, 32'h00020008, 4'h8, '0, '0);
        access(1'b0, 1'b0, 32'h00010008, 4'h1, 36'hABC123008, 3'b100);
        summarize();
    end
endmodule
